// ==== rtl/rps_sequencer.sv ====
module rps_sequencer
    import rps_pkg::*;
(
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic clk_en,
    // Time base and control pins
    input  wire logic timebase_tick,
    input  wire logic enable_in,
    input  wire logic output_polarity_select,
    // Rail release open-drain pins
    output logic      rail_release_out_1,
    output logic      rail_release_out_2,
    output logic      rail_release_out_3,
    output logic      rail_release_oe_n_1,
    output logic      rail_release_oe_n_2,
    output logic      rail_release_oe_n_3
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    logic [1:0] en_sync_reg;
    logic [1:0] tick_sync_reg;
    logic [1:0] pol_sync_reg;
    logic       tick_prev_reg;
    logic       tick_pulse;

    // enable, tick and polarity synchronisers
    // Pins are asynchronous; first stage is read only by the second
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            en_sync_reg   <= 2'h0;
            tick_sync_reg <= 2'h0;
            pol_sync_reg  <= 2'h0;
            tick_prev_reg <= 1'b0;
        end else if (clk_en) begin
            en_sync_reg   <= {en_sync_reg[0], enable_in};
            tick_sync_reg <= {tick_sync_reg[0], timebase_tick};
            pol_sync_reg  <= {pol_sync_reg[0], output_polarity_select};
            tick_prev_reg <= tick_sync_reg[1];
        end
    end

    // one count per time-base rising edge
    assign tick_pulse = tick_sync_reg[1] & ~tick_prev_reg;

    wire logic en_s  = en_sync_reg[1];
    wire logic pol_s = pol_sync_reg[1];

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    rps_state_t state_reg;
    rps_state_t state_next;
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    rps_rails_t rails_reg;
    rps_rails_t rails_next;

    // Counting starts at the next tick edge, so the first delay spans 8 to 9 periods
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        rails_next = rails_reg;
        case (state_reg)
            RPS_OFF: begin
                cnt_next = RPS_CNT_RESET;
                if (en_s)
                    state_next = RPS_UP1;
            end
            RPS_UP1: begin
                if (!en_s) begin
                    state_next = RPS_OFF;
                    cnt_next   = RPS_CNT_RESET;
                end else if (tick_pulse) begin
                    if (cnt_reg == RPS_FIRST_TICKS - 4'h1) begin
                        rails_next.rail1 = 1'b1;
                        cnt_next         = RPS_CNT_RESET;
                        state_next       = RPS_UP2;
                    end else begin
                        cnt_next = cnt_reg + 4'h1;
                    end
                end
            end
            RPS_UP2: begin
                if (!en_s) begin
                    state_next = RPS_DN1;
                    cnt_next   = RPS_CNT_RESET;
                end else if (tick_pulse) begin
                    if (cnt_reg == RPS_STEP_TICKS - 4'h1) begin
                        rails_next.rail2 = 1'b1;
                        cnt_next         = RPS_CNT_RESET;
                        state_next       = RPS_UP3;
                    end else begin
                        cnt_next = cnt_reg + 4'h1;
                    end
                end
            end
            RPS_UP3: begin
                if (!en_s) begin
                    state_next = RPS_DN2;
                    cnt_next   = RPS_CNT_RESET;
                end else if (tick_pulse) begin
                    if (cnt_reg == RPS_STEP_TICKS - 4'h1) begin
                        rails_next.rail3 = 1'b1;
                        cnt_next         = RPS_CNT_RESET;
                        state_next       = RPS_ON;
                    end else begin
                        cnt_next = cnt_reg + 4'h1;
                    end
                end
            end
            RPS_ON: begin
                cnt_next = RPS_CNT_RESET;
                if (!en_s)
                    state_next = RPS_DN3;
            end
            RPS_DN3: begin
                if (tick_pulse) begin
                    if (cnt_reg == RPS_FIRST_TICKS - 4'h1) begin
                        rails_next.rail3 = 1'b0;
                        cnt_next         = RPS_CNT_RESET;
                        state_next       = RPS_DN2;
                    end else begin
                        cnt_next = cnt_reg + 4'h1;
                    end
                end
            end
            RPS_DN2: begin
                if (tick_pulse) begin
                    if (cnt_reg == RPS_STEP_TICKS - 4'h1) begin
                        rails_next.rail2 = 1'b0;
                        cnt_next         = RPS_CNT_RESET;
                        state_next       = RPS_DN1;
                    end else begin
                        cnt_next = cnt_reg + 4'h1;
                    end
                end
            end
            RPS_DN1: begin
                // OFF then restarts if enable is high again
                if (tick_pulse) begin
                    if (cnt_reg == RPS_STEP_TICKS - 4'h1) begin
                        rails_next.rail1 = 1'b0;
                        cnt_next         = RPS_CNT_RESET;
                        state_next       = RPS_OFF;
                    end else begin
                        cnt_next = cnt_reg + 4'h1;
                    end
                end
            end
            default: begin
                state_next = RPS_OFF;
                cnt_next   = RPS_CNT_RESET;
                rails_next = RPS_RAILS_RESET;
            end
        endcase
    end

    // State registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_reg <= RPS_OFF;
            cnt_reg   <= RPS_CNT_RESET;
            rails_reg <= RPS_RAILS_RESET;
        end else if (clk_en) begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            rails_reg <= rails_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output drivers

    // polarity high gives active low
    // Pin level is registered, and oe_n low means the pull-down is on
    // Released pin level is rail XOR polarity, so oe_n carries that same level
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rail_release_out_1  <= 1'b0;
            rail_release_out_2  <= 1'b0;
            rail_release_out_3  <= 1'b0;
            rail_release_oe_n_1 <= 1'b0;
            rail_release_oe_n_2 <= 1'b0;
            rail_release_oe_n_3 <= 1'b0;
        end else if (clk_en) begin
            rail_release_out_1  <= 1'b0;
            rail_release_out_2  <= 1'b0;
            rail_release_out_3  <= 1'b0;
            rail_release_oe_n_1 <= rails_next.rail1 ^ pol_s;
            rail_release_oe_n_2 <= rails_next.rail2 ^ pol_s;
            rail_release_oe_n_3 <= rails_next.rail3 ^ pol_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n || !clk_en);

    hold_off_a: assert property (state_reg == RPS_OFF |-> rails_reg == RPS_RAILS_RESET)
        else $error("rails released while idle");
    first_rel_a: assert property ($rose(rails_reg.rail1) |-> $past(cnt_reg) == RPS_FIRST_TICKS - 4'h1 && $past(state_reg) == RPS_UP1)
        else $error("first rail released at wrong count");
    second_rel_a: assert property ($rose(rails_reg.rail2) |-> $past(cnt_reg) == RPS_STEP_TICKS - 4'h1 && rails_reg.rail1)
        else $error("second rail released out of order");
    third_rel_a: assert property ($rose(rails_reg.rail3) |-> rails_reg.rail2 && state_reg == RPS_ON)
        else $error("third rail released out of order");
    third_off_a: assert property ($fell(rails_reg.rail3) |-> $past(cnt_reg) == RPS_FIRST_TICKS - 4'h1 && state_reg == RPS_DN2)
        else $error("third rail dropped at wrong count");
    rev_order_a: assert property ($fell(rails_reg.rail1) |-> !rails_reg.rail2 && !rails_reg.rail3)
        else $error("first rail dropped before others");
    abort_up_a: assert property (state_reg == RPS_UP1 && !en_s |=> state_reg == RPS_OFF && rails_reg == RPS_RAILS_RESET)
        else $error("early enable drop not aborted");
    ctrl_down_a: assert property (state_reg == RPS_UP3 && !en_s |=> state_reg == RPS_DN2 && rails_reg.rail1)
        else $error("mid power-up drop not reversed");
    polarity_a: assert property (##1 rail_release_oe_n_1 == (rails_reg.rail1 ^ $past(pol_s)))
        else $error("rail one polarity wrong");
    restart_a: assert property (state_reg == RPS_DN1 && en_s |=> state_reg inside {RPS_DN1, RPS_OFF})
        else $error("power-down interrupted by enable");

    full_up_c: cover property (state_reg == RPS_UP3 ##1 state_reg == RPS_ON);
    full_down_c: cover property (state_reg == RPS_DN1 ##1 state_reg == RPS_OFF);
    abort_c: cover property (state_reg == RPS_UP1 ##1 state_reg == RPS_OFF);
    inverted_c: cover property (pol_s && state_reg == RPS_ON);

endmodule : rps_sequencer

// ==== rtl/rps_pkg.sv ====
// Summary of operation
// - With polarity low, all rail outputs stay inactive after reset until enable is seen asserted.
// - After enable asserts, first rail releases on the ninth time-base tick, eight to nine periods later.
// - Second rail releases exactly eight ticks after the first one.
// - Third rail releases eight ticks after the second, completing power-up.
// - After enable drops, third rail goes inactive on the ninth tick, eight to nine periods later.
// - Then second and first rails go inactive, eight ticks apart.
// - Polarity low: released outputs high, inactive outputs driven low.
// - All delays are counted in periods of the time-base tick.
// - Enable dropping before the first release aborts the count, outputs stay inactive.
// - Enable dropping mid power-up gives a controlled reverse shutdown of released rails.
// - Polarity high: released outputs low, inactive outputs high.
package rps_pkg;

    // Delays in time-base ticks
    localparam logic [3:0] RPS_FIRST_TICKS = 4'h9;
    localparam logic [3:0] RPS_STEP_TICKS  = 4'h8;
    localparam logic [3:0] RPS_CNT_RESET   = 4'h0;

    // Sequencer states
    typedef enum logic [2:0] {
        RPS_OFF,
        RPS_UP1,
        RPS_UP2,
        RPS_UP3,
        RPS_ON,
        RPS_DN3,
        RPS_DN2,
        RPS_DN1
    } rps_state_t;

    // Rail release vector, bit 0 is rail one
    typedef struct packed {
        logic rail3;
        logic rail2;
        logic rail1;
    } rps_rails_t;

    localparam rps_rails_t RPS_RAILS_RESET = 3'h0;

endpackage : rps_pkg

// ==== verification/rps_regulator_model.sv ====
////////////////////////////////////////////////////////////////////////////
// Regulator enable inputs behind pulled-up open-drain rail pins
module rps_regulator_model (
    // Open-drain drive from the sequencer
    input  wire logic [2:0] drain_out,
    input  wire logic [2:0] drain_oe_n,
    // Regulator enable sense
    input  wire logic       enable_active_low,
    // Observed levels
    output logic [2:0]      pin_level,
    output logic [2:0]      regulator_on
);
    timeunit 1ns;
    timeprecision 1ps;

    // Pull-up wins whenever the drain lets go; a stray out bit shows only while oe_n is low
    assign pin_level    = (drain_oe_n & 3'h7) | (~drain_oe_n & drain_out);
    // Regulator runs when its enable pin sits at its active level
    assign regulator_on = pin_level ^ {3{enable_active_low}};
endmodule : rps_regulator_model

// ==== verification/tb_top.sv ====
////////////////////////////////////////////////////////////////////////////
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic       sys_clk, rst_n, clk_en, timebase_tick, enable_in, output_polarity_select;
    logic       o1, o2, o3, e1, e2, e3;
    logic [2:0] pin_level;
    int         bad_count, checks_done, rel, cnt, seed;
    bit         down, first;
    logic       en_r;

    // Device under test
    rps_sequencer u_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .timebase_tick(timebase_tick),
        .enable_in(enable_in), .output_polarity_select(output_polarity_select),
        .rail_release_out_1(o1), .rail_release_out_2(o2), .rail_release_out_3(o3),
        .rail_release_oe_n_1(e1), .rail_release_oe_n_2(e2), .rail_release_oe_n_3(e3)
    );

    // Far side regulators follow the same polarity as the sequencer
    rps_regulator_model u_reg (
        .drain_out({o3, o2, o1}), .drain_oe_n({e3, e2, e1}),
        .enable_active_low(output_polarity_select), .pin_level(pin_level), .regulator_on()
    );

    // 200 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Compare pin levels with a given vector
    task automatic check_level(input logic [2:0] exp);
        checks_done++;
        if (pin_level !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t pins %b expected %b", $time, pin_level, exp);
        end
    endtask : check_level

    // Reference sequencer, stepped once per time-base tick
    task automatic model_step();
        int need;
        if (down || (!enable_in && rel > 0)) begin
            if (!down) begin
                down  = 1'b1;
                cnt   = 0;
                first = (rel == 3);
            end
            cnt++;
            need = first ? 9 : 8;
            if (cnt == need) begin
                rel--;
                cnt   = 0;
                first = 1'b0;
                down  = (rel > 0);
            end
        end else if (enable_in && rel < 3) begin
            cnt++;
            need = (rel == 0) ? 9 : 8;
            if (cnt == need) begin
                rel++;
                cnt = 0;
            end
        end else begin
            cnt = 0;
        end
    endtask : model_step

    // One tick period of 12 cycles; enable moves well clear of tick edges
    task automatic run(input int n, input logic en_val, input bit frz = 1'b0);
        for (int k = 0; k < n; k++) begin
            @(negedge sys_clk);
            timebase_tick = 1'b1;
            if (!frz) model_step();
            repeat (6) @(negedge sys_clk);
            timebase_tick = 1'b0;
            repeat (2) @(negedge sys_clk);
            check_level({rel > 2, rel > 1, rel > 0} ^ {3{output_polarity_select}});
            @(negedge sys_clk);
            enable_in = en_val;
            repeat (2) @(negedge sys_clk);
        end
    endtask : run

    // Polarity changes only while every rail is off
    task automatic set_pol(input logic p);
        output_polarity_select = p;
        repeat (6) @(negedge sys_clk);
    endtask : set_pol

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    // Main sequence
    initial begin
        seed = 32'h74de;
        {rst_n, timebase_tick, enable_in, output_polarity_select} = 4'h0;
        clk_en = 1'b1;
        {bad_count, checks_done, rel, cnt} = '0;
        {down, first} = 2'b00;
        repeat (2) @(negedge sys_clk);
        check_level(3'h0);
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        run(3, 1'b0);
        run(30, 1'b1);
        run(30, 1'b0);
        $display("test polarity low done");
        set_pol(1'b1);
        run(30, 1'b1);
        run(30, 1'b0);
        set_pol(1'b0);
        $display("test polarity high done");
        run(6, 1'b1);
        run(12, 1'b0);
        $display("test abort done");
        // drop after first and after second release
        run(14, 1'b1);
        run(20, 1'b0);
        run(22, 1'b1);
        run(25, 1'b0);
        $display("test partial done");
        run(6, 1'b1);
        clk_en = 1'b0;
        run(3, 1'b1, 1'b1);
        clk_en = 1'b1;
        run(30, 1'b1);
        run(30, 1'b0);
        $display("test freeze done");
        en_r = 1'b0;
        for (int i = 0; i < 300; i++) begin
            if (($random(seed) & 7) == 0) en_r = ~en_r;
            run(1, en_r);
        end
        $display("test random done");
        test_done();
    end
endmodule : tb_top
